// ### src/ais_input_select.sv
// converter input selection, scan sequencing and pin configuration
// assumes an apb3 master, conv_start pulses once per conversion and the
// dma side supplies the word index of each result within its input slot
`default_nettype none
module ais_input_select #(
  parameter int unsigned NUM_INPUTS  = 32,
  parameter bit          SECOND_UNIT = 1'b0
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [ais_pkg::AIS_AW-1:0] paddr,
  input  wire logic [ais_pkg::AIS_DW-1:0] pwdata,
  output logic      [ais_pkg::AIS_DW-1:0] prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     conv_start,
  input  wire logic [6:0]               dma_word_idx,
  output ais_pkg::ais_sel_t             sel_out,
  output logic      [31:0]              pin_digital,
  output logic      [7:0]               words_per_input,
  output logic      [11:0]              dma_addr
);
  // second unit reaches only the low sixteen inputs
  localparam int unsigned PHYS = SECOND_UNIT ?
    ((NUM_INPUTS < ais_pkg::AIS_SECOND_UNIT_INPUTS) ? NUM_INPUTS :
     ais_pkg::AIS_SECOND_UNIT_INPUTS) : NUM_INPUTS;

  logic [31:0] phys_mask;
  for (genvar i = 0; i < 32; i++) begin : g_phys
    assign phys_mask[i] = (i < PHYS);
  end

  logic [2:0]                  buf_code_q, buf_code_d;
  logic [15:0]                 multi_q, multi_d;
  logic [15:0]                 chan0_q, chan0_d;
  logic [31:0]                 scan_mask_q, scan_mask_d;
  logic [31:0]                 pin_digital_select_q, pin_digital_select_d;
  logic [ais_pkg::AIS_MD_W-1:0] mode_q, mode_d;
  logic [31:0]                 prdata_q, prdata_d;
  logic                        pready_q, pready_d;
  logic                        pslverr_q, pslverr_d;

  logic setup;
  logic wr_go;
  logic hit;
  logic wide;
  logic [31:0] status_word;
  assign setup = psel && !penable;
  assign wr_go = psel && penable && pready_q && pwrite && !pslverr_q;
  assign wide  = mode_q[ais_pkg::AIS_MD_WIDE];

  always_comb begin
    hit = 1'b1;
    unique case (paddr)
      ais_pkg::AIS_OFF_BUF_SIZE, ais_pkg::AIS_OFF_CHS123,
      ais_pkg::AIS_OFF_CHS0, ais_pkg::AIS_OFF_SCAN_HI,
      ais_pkg::AIS_OFF_SCAN_LO, ais_pkg::AIS_OFF_PIN_DIGITAL_SELECT_LO,
      ais_pkg::AIS_OFF_MODE, ais_pkg::AIS_OFF_STATUS: hit = 1'b1;
      ais_pkg::AIS_OFF_PIN_DIGITAL_SELECT_HI: hit = !SECOND_UNIT;
      default: hit = 1'b0;
    endcase
  end

  // bus answers in the first access cycle; data is captured at setup
  always_comb begin
    pready_d  = setup;
    pslverr_d = setup && !hit;
    prdata_d  = '0;
    if (setup && !pwrite) begin
      unique case (paddr)
        ais_pkg::AIS_OFF_BUF_SIZE: prdata_d = {29'h0, buf_code_q};
        ais_pkg::AIS_OFF_CHS123:
          prdata_d = wide ? 32'h0 : {16'h0, multi_q};
        ais_pkg::AIS_OFF_CHS0:    prdata_d = {16'h0, chan0_q};
        ais_pkg::AIS_OFF_SCAN_HI: prdata_d = {16'h0, scan_mask_q[31:16]};
        ais_pkg::AIS_OFF_SCAN_LO: prdata_d = {16'h0, scan_mask_q[15:0]};
        ais_pkg::AIS_OFF_PIN_DIGITAL_SELECT_HI:
          prdata_d = SECOND_UNIT ? 32'h0 : {16'h0, pin_digital_select_q[31:16]};
        ais_pkg::AIS_OFF_PIN_DIGITAL_SELECT_LO: prdata_d = {16'h0, pin_digital_select_q[15:0]};
        ais_pkg::AIS_OFF_MODE:    prdata_d = {28'h0, mode_q};
        ais_pkg::AIS_OFF_STATUS:  prdata_d = status_word;
        default:                  prdata_d = '0;
      endcase
    end
  end

  always_comb begin
    buf_code_d  = buf_code_q;
    multi_d     = multi_q;
    chan0_d     = chan0_q;
    scan_mask_d = scan_mask_q;
    pin_digital_select_d      = pin_digital_select_q;
    mode_d      = mode_q;
    if (wr_go) begin
      unique case (paddr)
        ais_pkg::AIS_OFF_BUF_SIZE: buf_code_d = pwdata[2:0];
        ais_pkg::AIS_OFF_CHS123:
          multi_d = pwdata[15:0] & ais_pkg::AIS_M_IMPL_MASK;
        ais_pkg::AIS_OFF_CHS0:
          chan0_d = pwdata[15:0] & ais_pkg::AIS_C0_IMPL_MASK;
        ais_pkg::AIS_OFF_SCAN_HI: scan_mask_d[31:16] = pwdata[15:0];
        ais_pkg::AIS_OFF_SCAN_LO: scan_mask_d[15:0] = pwdata[15:0];
        ais_pkg::AIS_OFF_PIN_DIGITAL_SELECT_HI: pin_digital_select_d[31:16] = pwdata[15:0];
        ais_pkg::AIS_OFF_PIN_DIGITAL_SELECT_LO: pin_digital_select_d[15:0] = pwdata[15:0];
        ais_pkg::AIS_OFF_MODE:    mode_d = pwdata[ais_pkg::AIS_MD_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_code_q  <= '0;
      multi_q     <= ais_pkg::AIS_RST_VAL;
      chan0_q     <= ais_pkg::AIS_RST_VAL;
      scan_mask_q <= '0;
      pin_digital_select_q      <= '0;
      mode_q      <= '0;
      prdata_q    <= '0;
      pready_q    <= 1'b0;
      pslverr_q   <= 1'b0;
    end else begin
      buf_code_q  <= buf_code_d;
      multi_q     <= multi_d;
      chan0_q     <= chan0_d;
      scan_mask_q <= scan_mask_d;
      pin_digital_select_q      <= pin_digital_select_d;
      mode_q      <= mode_d;
      prdata_q    <= prdata_d;
      pready_q    <= pready_d;
      pslverr_q   <= pslverr_d;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // lowest selected input at or after 'from', wrapping; msb says found
  function automatic logic [5:0] scan_pick(input logic [31:0] m,
                                           input logic [4:0]  from);
    logic [5:0] r;
    logic [4:0] k;
    r = '0;
    for (int i = 31; i >= 0; i--) begin
      k = from + 5'(i);
      if (m[k]) r = {1'b1, k};
    end
    return r;
  endfunction

  logic        phase_b_q, phase_b_d;
  logic [4:0]  scan_ptr_q, scan_ptr_d;
  logic [11:0] order_cnt_q, order_cnt_d;
  logic [5:0]  pick;
  logic        scanning;
  logic [4:0]  cur_in;
  assign pick     = scan_pick(scan_mask_q, scan_ptr_q);
  assign scanning = mode_q[ais_pkg::AIS_MD_SCAN] && !phase_b_q && pick[5];
  assign status_word = {26'h0, phase_b_q, scan_ptr_q};

  always_comb begin
    phase_b_d   = phase_b_q;
    scan_ptr_d  = scan_ptr_q;
    order_cnt_d = order_cnt_q;
    if (!mode_q[ais_pkg::AIS_MD_ALT]) phase_b_d = 1'b0;
    if (conv_start) begin
      order_cnt_d = order_cnt_q + 12'h001;
      if (mode_q[ais_pkg::AIS_MD_ALT]) phase_b_d = !phase_b_q;
      if (scanning) scan_ptr_d = pick[4:0] + 5'h01;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      phase_b_q   <= 1'b0;
      scan_ptr_q  <= '0;
      order_cnt_q <= '0;
    end else begin
      phase_b_q   <= phase_b_d;
      scan_ptr_q  <= scan_ptr_d;
      order_cnt_q <= order_cnt_d;
    end
  end

  ais_pkg::ais_sel_t sel_q, sel_d;
  logic [31:0]       pin_dig_q, pin_dig_d;
  logic [7:0]        words_q, words_d;
  logic [11:0]       dma_addr_q, dma_addr_d;
  logic [11:0]       slot_mask;
  logic [1:0]        neg_code;
  logic              pos_hi;

  always_comb begin
    sel_d = '0;
    sel_d.phase_b = phase_b_q;
    if (scanning) begin
      cur_in = pick[4:0];
    end else if (phase_b_q) begin
      cur_in = chan0_q[ais_pkg::AIS_C0_POS_B_LSB +: 5];
    end else begin
      cur_in = chan0_q[ais_pkg::AIS_C0_POS_A_LSB +: 5];
    end
    sel_d.ch0_pos     = cur_in;
    sel_d.ch0_pos_ref = !phys_mask[cur_in];
    sel_d.ch0_neg_in1 = phase_b_q ? chan0_q[ais_pkg::AIS_C0_NEG_B_BIT]
                                  : chan0_q[ais_pkg::AIS_C0_NEG_A_BIT];
    neg_code = phase_b_q ? multi_q[ais_pkg::AIS_M_NEG_B_LSB +: 2]
                         : multi_q[ais_pkg::AIS_M_NEG_A_LSB +: 2];
    pos_hi   = phase_b_q ? multi_q[ais_pkg::AIS_M_POS_B_BIT]
                         : multi_q[ais_pkg::AIS_M_POS_A_BIT];
    sel_d.multi_en      = !wide;
    sel_d.multi_neg_ref = wide || !neg_code[1];
    for (int c = 0; c < 3; c++) begin
      sel_d.multi_pos[c] = wide ? 5'h00 : (pos_hi ?
        ais_pkg::AIS_POS_HIGH_BASE : ais_pkg::AIS_POS_LOW_BASE) + 5'(c);
      if (wide || !neg_code[1]) begin
        sel_d.multi_neg[c] = 5'h00;
      end else if (neg_code == ais_pkg::AIS_NEG_HIGH) begin
        sel_d.multi_neg[c] = ais_pkg::AIS_NEG_HIGH_BASE + 5'(c);
      end else begin
        sel_d.multi_neg[c] = ais_pkg::AIS_NEG_MID_BASE + 5'(c);
      end
    end
    // digital pins ground the mux; absent inputs are ignored
    pin_dig_d = pin_digital_select_q & phys_mask;
    words_d   = 8'h01 << buf_code_q;
    slot_mask = (12'h001 << buf_code_q) - 12'h001;
    dma_addr_d = dma_addr_q;
    if (conv_start) begin
      if (mode_q[ais_pkg::AIS_MD_ORDER]) begin
        dma_addr_d = order_cnt_q;
      end else begin
        dma_addr_d = ({7'h00, cur_in} << buf_code_q) |
                     ({5'h00, dma_word_idx} & slot_mask);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_q      <= '0;
      pin_dig_q  <= '0;
      words_q    <= 8'h01;
      dma_addr_q <= '0;
    end else begin
      sel_q      <= sel_d;
      pin_dig_q  <= pin_dig_d;
      words_q    <= words_d;
      dma_addr_q <= dma_addr_d;
    end
  end
  assign sel_out         = sel_q;
  assign pin_digital     = pin_dig_q;
  assign words_per_input = words_q;
  assign dma_addr        = dma_addr_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_read(logic [7:0] a);
    setup && !pwrite && paddr == a ##1 psel && penable;
  endsequence
  sequence s_write(logic [7:0] a);
    setup && pwrite && paddr == a ##1 psel && penable;
  endsequence

  a_bufsize_upper_zero: assert property (
    s_read(ais_pkg::AIS_OFF_BUF_SIZE) |-> pready && prdata[31:3] == '0)
    else $error("buffer size upper bits not zero");
  a_words_decode: assert property (
    ##1 words_per_input == (8'h01 << $past(buf_code_q)))
    else $error("words per input decode wrong");
  a_wide_hides_multi: assert property (
    (wide and s_read(ais_pkg::AIS_OFF_CHS123)) |-> prdata == '0)
    else $error("multi select visible in wide mode");
  a_multi_neg_map: assert property (
    !wide && phase_b_q && multi_q[10:9] == ais_pkg::AIS_NEG_HIGH |=>
    sel_out.multi_neg[2] == 5'h0B && !sel_out.multi_neg_ref)
    else $error("sample b negative mapping wrong");
  a_multi_pos_map: assert property (
    !wide && !phase_b_q && multi_q[0] |=> sel_out.multi_pos[0] == 5'h03)
    else $error("sample a positive mapping wrong");
  a_ch0_neg_sel: assert property (
    phase_b_q |=> sel_out.ch0_neg_in1 == $past(chan0_q[15]))
    else $error("channel 0 negative select wrong");
  a_ch0_pos_fixed: assert property (
    !mode_q[ais_pkg::AIS_MD_SCAN] && !phase_b_q |=>
    sel_out.ch0_pos == $past(chan0_q[4:0]))
    else $error("channel 0 positive select wrong");
  a_scan_low_write: assert property (
    s_write(ais_pkg::AIS_OFF_SCAN_LO) |=>
    scan_mask_q[15:0] == $past(pwdata[15:0]))
    else $error("scan mask low not written");
  a_scan_absent_ref: assert property (
    sel_out.ch0_pos_ref == (32'(sel_out.ch0_pos) >= PHYS))
    else $error("absent input not routed to reference");
  a_phase_alternates: assert property (
    conv_start && mode_q[ais_pkg::AIS_MD_ALT] |=>
    phase_b_q != $past(phase_b_q))
    else $error("alternate sampling did not toggle");
  a_scan_advance: assert property (
    conv_start && scanning |=> scan_ptr_q == $past(pick[4:0]) + 5'h01)
    else $error("scan pointer did not advance");
  a_pin_absent_off: assert property (
    (pin_digital & ~phys_mask) == '0)
    else $error("absent pin configuration took effect");

  // these watch registered outputs one edge after the cause
  a_high_cfg_err: assert property (
    setup && paddr == ais_pkg::AIS_OFF_PIN_DIGITAL_SELECT_HI |=> pslverr == SECOND_UNIT)
    else $error("high pin configuration error answer wrong");
  a_pin_digital_select_high_write: assert property (
    s_write(ais_pkg::AIS_OFF_PIN_DIGITAL_SELECT_HI) |=> pin_digital_select_q[31:16] == (SECOND_UNIT ?
    $past(pin_digital_select_q[31:16]) : $past(pwdata[15:0])))
    else $error("high pin configuration write wrong");
  a_ch0_neg_a: assert property (
    !phase_b_q |=> sel_out.ch0_neg_in1 == $past(chan0_q[7]))
    else $error("channel 0 sample a negative select wrong");
  a_ch0_pos_b: assert property (
    phase_b_q |=> sel_out.ch0_pos == $past(chan0_q[12:8]))
    else $error("channel 0 sample b positive select wrong");
  a_multi_neg_ref: assert property (
    !wide && !phase_b_q && !multi_q[2] |=> sel_out.multi_neg_ref)
    else $error("sample a negative reference not chosen");
  a_multi_mid_map: assert property (
    !wide && !phase_b_q && multi_q[2:1] == ais_pkg::AIS_NEG_MID |=>
    sel_out.multi_neg[0] == 5'h06 && !sel_out.multi_neg_ref)
    else $error("sample a middle negative mapping wrong");
  a_multi_pos_b: assert property (
    !wide && phase_b_q && !multi_q[8] |=> sel_out.multi_pos[2] == 5'h02)
    else $error("sample b low positive mapping wrong");
  a_wide_multi_off: assert property (
    wide |=> !sel_out.multi_en && sel_out.multi_pos[1] == 5'h00)
    else $error("multi channel outputs live in wide mode");
  a_alt_off_phase: assert property (
    !mode_q[ais_pkg::AIS_MD_ALT] |=> !phase_b_q)
    else $error("sample b used without alternate mode");
  a_scatter_addr: assert property (
    conv_start && !mode_q[ais_pkg::AIS_MD_ORDER] && buf_code_q == 3'h7 |=>
    dma_addr == {$past(cur_in), $past(dma_word_idx)})
    else $error("scatter gather address wrong");
  a_order_addr: assert property (
    conv_start && mode_q[ais_pkg::AIS_MD_ORDER] |=>
    dma_addr == $past(order_cnt_q))
    else $error("conversion order address wrong");
  a_pin_digital_map: assert property (
    ##1 pin_digital[0] == $past(pin_digital_select_q[0]))
    else $error("pin digital select not applied");
endmodule
`default_nettype wire

// ### src/ais_pkg.sv
// constants and carrier types for the converter input select block
// assumes an apb master on the register side and analog muxes that
// take decoded input indices one cycle after a change
// Operation
// - buffer-size code n gives 2^n words per input, 1 to 128
// - buffer-size register bits 15 to 3 always read zero
// - sample B multi negative: 11 inputs 9-11, 10 inputs 6-8, 0x reference
// - sample A multi negative uses same coding at bits 2 to 1
// - sample B multi positive: one picks inputs 3-5, zero picks 0-2
// - sample A multi positive uses same mapping from bit 0
// - in 12-bit mode all multi-channel selects read zero and are unused
// - channel 0 negative: one is input 1, zero is reference; bits 7, 15
// - channel 0 positive code n selects input n; bits 4-0 and 12-8
// - 32-bit scan mask in high and low words; one includes input n
// - any mask bit settable; absent input converts the negative reference
// - pin config one: digital, port read on, mux grounded; zero: analog
// - all pin config bits read/write; bits without input have no effect
// - second unit has inputs 0-15 only and no high pin config register
// - mode bit one selects 12-bit single channel, zero 10-bit four channel
// - scan enable steps channel 0 positive through scan inputs in sample A
// - alternate mode uses sample A then B selects in turn, else always A
// - scatter/gather forms dma address from input index and buffer size
`default_nettype none
package ais_pkg;
  localparam int unsigned AIS_AW = 8;
  localparam int unsigned AIS_DW = 32;
  localparam logic [7:0] AIS_OFF_BUF_SIZE = 8'h00;
  localparam logic [7:0] AIS_OFF_CHS123   = 8'h04;
  localparam logic [7:0] AIS_OFF_CHS0     = 8'h08;
  localparam logic [7:0] AIS_OFF_SCAN_HI  = 8'h0C;
  localparam logic [7:0] AIS_OFF_SCAN_LO  = 8'h10;
  localparam logic [7:0] AIS_OFF_PIN_DIGITAL_SELECT_HI  = 8'h14;
  localparam logic [7:0] AIS_OFF_PIN_DIGITAL_SELECT_LO  = 8'h18;
  localparam logic [7:0] AIS_OFF_MODE     = 8'h1C;
  localparam logic [7:0] AIS_OFF_STATUS   = 8'h20;
  localparam logic [15:0] AIS_RST_VAL     = 16'h0000;
  localparam int unsigned AIS_BUF_W       = 3;
  localparam int unsigned AIS_M_NEG_B_LSB = 9;
  localparam int unsigned AIS_M_POS_B_BIT = 8;
  localparam int unsigned AIS_M_NEG_A_LSB = 1;
  localparam int unsigned AIS_M_POS_A_BIT = 0;
  localparam logic [15:0] AIS_M_IMPL_MASK = 16'h0707;
  localparam int unsigned AIS_C0_NEG_B_BIT = 15;
  localparam int unsigned AIS_C0_POS_B_LSB = 8;
  localparam int unsigned AIS_C0_NEG_A_BIT = 7;
  localparam int unsigned AIS_C0_POS_A_LSB = 0;
  localparam logic [15:0] AIS_C0_IMPL_MASK = 16'h9F9F;
  localparam int unsigned AIS_MD_WIDE  = 0;
  localparam int unsigned AIS_MD_SCAN  = 1;
  localparam int unsigned AIS_MD_ALT   = 2;
  localparam int unsigned AIS_MD_ORDER = 3;
  localparam int unsigned AIS_MD_W     = 4;
  localparam logic [1:0] AIS_NEG_HIGH = 2'b11;
  localparam logic [1:0] AIS_NEG_MID  = 2'b10;
  localparam logic [4:0] AIS_NEG_HIGH_BASE = 5'h09;
  localparam logic [4:0] AIS_NEG_MID_BASE  = 5'h06;
  localparam logic [4:0] AIS_POS_HIGH_BASE = 5'h03;
  localparam logic [4:0] AIS_POS_LOW_BASE  = 5'h00;
  localparam logic [4:0] AIS_C0_NEG_INPUT  = 5'h01;
  localparam int unsigned AIS_SECOND_UNIT_INPUTS = 16;

  typedef struct packed {
    logic            phase_b;
    logic [4:0]      ch0_pos;
    logic            ch0_pos_ref;
    logic            ch0_neg_in1;
    logic            multi_en;
    logic [2:0][4:0] multi_pos;
    logic [2:0][4:0] multi_neg;
    logic            multi_neg_ref;
  } ais_sel_t;
endpackage
`default_nettype wire

// ### test/adc_input_select_config_tb.sv
// self-checking bench for the converter input select block
// assumes a zero-wait apb slave; the mux model stands on the analog side
`default_nettype none
module adc_input_select_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NIN = 20;
  localparam logic [4:0] SCAN_SEQ [4] = '{5'h00, 5'h02, 5'h1F, 5'h00};
  logic              ref_clk = 1'b0;
  logic              rst, psel, penable, pwrite, conv_start;
  logic              pready, pslverr, slverr2, err;
  logic [7:0]        paddr, words_per_input, level;
  logic [6:0]        dma_word_idx;
  logic [31:0]       pwdata, prdata, pin_digital, rd, pin_digital_select;
  logic [11:0]       dma_addr;
  logic [15:0]       seed, d, c0;
  ais_pkg::ais_sel_t sel_out;
  int                err_count, num_checks, n_conv;

  always #2.5 ref_clk = ~ref_clk;

  ais_input_select #(.NUM_INPUTS(NIN), .SECOND_UNIT(1'b0)) dut (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
    .dma_word_idx(dma_word_idx), .sel_out(sel_out),
    .pin_digital(pin_digital), .words_per_input(words_per_input),
    .dma_addr(dma_addr));
  // second unit shares the bus; only its error answer is watched
  logic slverr2_w;
  ais_input_select #(.NUM_INPUTS(16), .SECOND_UNIT(1'b1)) dut2 (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
    .pready(), .pslverr(slverr2_w), .conv_start(conv_start),
    .dma_word_idx(dma_word_idx), .sel_out(), .pin_digital(),
    .words_per_input(), .dma_addr());
  ais_mux_model #(.NUM_INPUTS(NIN)) model (
    .sel_out(sel_out), .pin_digital(pin_digital), .ch0_level(level));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] lvl(input logic [4:0] i);
    if (i >= NIN) return 8'hF0;
    if (pin_digital_select[i]) return 8'h00;
    return 8'h40 + {3'h0, i};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, then two edges so that sel_out has caught up
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [15:0] wd);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      chk("apb wait", 32'h0, 32'h1);
      test_done();
    end
    rd = prdata;
    err = pslverr;
    slverr2 = slverr2_w;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic conv(input logic [6:0] w);
    n_conv++;
    @(posedge ref_clk);
    conv_start <= 1'b1;
    dma_word_idx <= w;
    @(posedge ref_clk);
    conv_start <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    pin_digital_select = 32'h0;
    n_conv = 0;
  endtask
  task automatic mchk(input logic [2:0] f);
    for (int c = 0; c < 3; c++) begin
      chk("multi pos", sel_out.multi_pos[c], (f[0] ? 3 : 0) + c);
      if (f[2]) begin
        chk("multi neg", sel_out.multi_neg[c], (f[1] ? 9 : 6) + c);
      end
    end
    chk("multi neg ref", sel_out.multi_neg_ref, !f[2]);
  endtask

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, conv_start} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    dma_word_idx = 7'h00;
    err_count = 0;
    num_checks = 0;
    seed = 16'h0016;
    do_reset();
    for (int a = 0; a <= 32; a += 4) begin
      apb(1'b0, 8'(a), 16'h0000);
      chk("reset value", rd, 32'h0);
    end
    chk("words reset", words_per_input, 8'h01);
    apb(1'b0, 8'h24, 16'h0000);
    chk("unmapped err", err, 1'b1);
    apb(1'b1, 8'h14, 16'hFFFF);
    pin_digital_select = 32'hFFFF0000;
    chk("second unit high cfg", slverr2, 1'b1);
    apb(1'b0, 8'h14, 16'h0000);
    chk("pin high rd", rd, 32'hFFFF);
    chk("pin high", pin_digital[31:16], 16'h000F);
    for (int code = 0; code < 8; code++) begin
      seed = lfsr(seed);
      apb(1'b1, 8'h00, {seed[15:3], 3'(code)});
      chk("words", words_per_input, 1 << code);
      apb(1'b0, 8'h00, 16'h0000);
      chk("buf size rd", rd, code);
    end
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      d = seed;
      apb(1'b1, 8'h08, d);
      apb(1'b0, 8'h08, 16'h0000);
      chk("ch0 rd", rd, d & 16'h9F9F);
      chk("ch0 pos", sel_out.ch0_pos, d[4:0]);
      chk("ch0 neg", sel_out.ch0_neg_in1, d[7]);
      chk("ch0 ref", sel_out.ch0_pos_ref, d[4:0] >= NIN);
      chk("ch0 level", level, lvl(d[4:0]));
      c0 = d;
    end
    for (int i = 0; i < 8; i++) begin
      d = {5'h00, ~3'(i), 5'h00, 3'(i)};
      apb(1'b1, 8'h04, d);
      apb(1'b0, 8'h04, 16'h0000);
      chk("ch123 rd", rd, d);
      mchk(3'(i));
      apb(1'b1, 8'h1C, 16'h0004);
      conv(7'h00);
      chk("phase b", sel_out.phase_b, 1'b1);
      mchk(~3'(i));
      chk("ch0 pos b", sel_out.ch0_pos, c0[12:8]);
      conv(7'h00);
      chk("phase a", sel_out.phase_b, 1'b0);
      apb(1'b1, 8'h1C, 16'h0000);
    end
    apb(1'b1, 8'h1C, 16'h0001);
    apb(1'b0, 8'h04, 16'h0000);
    chk("wide rd", rd, 32'h0);
    chk("wide multi", sel_out.multi_en, 1'b0);
    apb(1'b1, 8'h1C, 16'h0000);
    chk("four chan", sel_out.multi_en, 1'b1);
    seed = lfsr(seed);
    apb(1'b1, 8'h18, seed);
    chk("pin low", pin_digital[15:0], seed);
    apb(1'b1, 8'h00, 16'h0002);
    apb(1'b1, 8'h08, 16'h0005);
    conv(7'h03);
    chk("dma addr", dma_addr, 12'h017);
    apb(1'b1, 8'h1C, 16'h0008);
    d = 16'(n_conv);
    conv(7'h00);
    chk("dma order", dma_addr, d);
    do_reset();
    chk("words rereset", words_per_input, 8'h01);
    apb(1'b1, 8'h10, 16'h0005);
    apb(1'b1, 8'h0C, 16'h8000);
    apb(1'b0, 8'h0C, 16'h0000);
    chk("scan high", rd, 32'h8000);
    apb(1'b1, 8'h18, 16'h0004);
    pin_digital_select = 32'h4;
    apb(1'b1, 8'h1C, 16'h0002);
    for (int s = 0; s < 4; s++) begin
      chk("scan input", sel_out.ch0_pos, SCAN_SEQ[s]);
      chk("scan level", level, lvl(SCAN_SEQ[s]));
      conv(7'h00);
    end
    test_done();
  end
endmodule
`default_nettype wire

// ### test/ais_mux_model.sv
// behavioural model of the analog muxes behind the select block
// assumes the decoded selects arrive one cycle after a register change
`default_nettype none
module ais_mux_model #(
  parameter int unsigned NUM_INPUTS = 32
) (
  input  wire ais_pkg::ais_sel_t sel_out,
  input  wire logic [31:0]       pin_digital,
  output logic      [7:0]        ch0_level
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] NEG_REF_LEVEL = 8'hF0;
  localparam logic [7:0] GROUND_LEVEL  = 8'h00;
  // trusts only the reference flag, so a missing flag shows as a pin level
  always_comb begin
    if (sel_out.ch0_pos_ref) begin
      ch0_level = NEG_REF_LEVEL;
    end else if (pin_digital[sel_out.ch0_pos]) begin
      ch0_level = GROUND_LEVEL;
    end else begin
      ch0_level = 8'h40 + {3'h0, sel_out.ch0_pos};
    end
  end
endmodule
`default_nettype wire
